// File: src/usu_cfg.svh
// Behaviour
// - a software write to shift data wins over a same-cycle shift clock
// - shift data moves left one bit per clock from the selected source
// - data and clock inputs stay usable even with outputs disabled
// - the data output pin follows shift bit 7 through an output latch
// - latch open half a serial cycle on external clock, always on internal
// - while the latch is open a newly written bit 7 reaches the pin
// - data reaches the output pin only when its direction bit is one
// - a completed transfer copies shift data into the receive buffer
// - reading the receive buffer affects flags exactly as reading shift data
// - in two-wire mode a detected start condition sets the start flag
// - off or three-wire, external source, strobe zero: any clock edge sets start
// - start and overflow interrupts need flag, own enable and global enable
// - start flag clears only by writing one; clearing releases its clock hold
// - a pending start interrupt asserts a wake request valid in all sleep modes
// - overflow flag sets when the 4-bit counter wraps from 15 to 0
// - overflow flag clears only by writing one; clearing releases its clock hold
// - a pending overflow interrupt wakes from idle sleep only
// - two-wire stop condition sets the stop flag, cleared by one, no interrupt
// - collision bit reads one when shift bit 7 differs from the data pin
// - status low nibble is the live counter, readable and writable
// - counter counts external edges, timer matches or software strobes
// - external source with strobe bit one: toggle strobe clocks the counter
// - wire mode 00 off, 01 three-wire, 10 two-wire open drain
// - two-wire with clock output on: clock held low while start flag is set
`ifndef USU_CFG_SVH
`define USU_CFG_SVH

// ==========================================================================
// register indices (byte address is four times the index)
`define USU_IDX_CONTROL  6'h0D
`define USU_IDX_STATUS   6'h0E
`define USU_IDX_DATA     6'h0F
`define USU_IDX_BUFFER   6'h10

// ==========================================================================
// control fields
`define USU_CTL_SIE      7
`define USU_CTL_OIE      6
`define USU_CTL_WM_HI    5
`define USU_CTL_WM_LO    4
`define USU_CTL_CS_HI    3
`define USU_CTL_CS_LO    2
`define USU_CTL_CLK      1
`define USU_CTL_TOG      0

// ==========================================================================
// status fields
`define USU_STS_START    7
`define USU_STS_OVF      6
`define USU_STS_STOP     5
`define USU_STS_COLL     4
`define USU_STS_CNT_HI   3

// ==========================================================================
// encodings and counts
`define USU_WM_OFF       2'h0
`define USU_WM_THREE     2'h1
`define USU_WM_TWO       2'h2
`define USU_CS_SOFT      2'h0
`define USU_CS_TIMER     2'h1
`define USU_CS_EXT_POS   2'h2
`define USU_CS_EXT_NEG   2'h3
`define USU_CNT_MAX      4'hF
`define USU_HSIZE_WORD   3'h2

// ==========================================================================
// reset values
`define USU_RST_CONTROL  8'h00
`define USU_RST_STATUS   8'h00
`define USU_RST_DATA     8'h00
`define USU_RST_BUFFER   8'h00

`endif

// File: src/usu_pkg.sv
// ==========================================================================
// shared types
package usu_pkg;

  typedef logic [31:0] usu_word_t;
  typedef logic [7:0]  usu_byte_t;

  typedef enum logic [0:0] {
    USU_BUS_IDLE,
    USU_BUS_DATA
  } usu_bus_phase_t;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } usu_sync_state_t;

  typedef struct packed {
    logic sda_prev;
    logic scl_prev;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } usu_detect_state_t;

endpackage

// File: src/usu_sync.sv
`timescale 1ns/100ps
// ==========================================================================
// two-stage synchroniser for pin inputs
module usu_sync (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  // pins
  input  wire logic [1:0] i_async,
  // synchronised levels
  output logic      [1:0] o_sync
);
  import usu_pkg::*;

  usu_sync_state_t state;
  usu_sync_state_t next_state;

  always_comb begin
    next_state        = state;
    next_state.stage1 = i_async;
    next_state.stage2 = state.stage1;
    if (i_srst) begin
      next_state = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    state <= next_state;
  end

  assign o_sync = state.stage2;

endmodule

// File: src/usu_cond_detect.sv
`timescale 1ns/100ps
// ==========================================================================
// start/stop condition and clock edge detector
module usu_cond_detect (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // synchronised line levels
  input  wire logic i_sda,
  input  wire logic i_scl,
  input  wire logic i_two_wire,
  // one-cycle events
  output logic      o_start,
  output logic      o_stop,
  output logic      o_scl_rise,
  output logic      o_scl_fall
);
  import usu_pkg::*;

  usu_detect_state_t state;
  usu_detect_state_t next_state;

  always_comb begin
    next_state          = state;
    next_state.sda_prev = i_sda;
    next_state.scl_prev = i_scl;
    // data falls while clock stays high
    next_state.start    = i_two_wire & i_scl & state.scl_prev & state.sda_prev & ~i_sda;
    // data rises while clock stays high
    next_state.stop     = i_two_wire & i_scl & state.scl_prev & ~state.sda_prev & i_sda;
    next_state.scl_rise = i_scl & ~state.scl_prev;
    next_state.scl_fall = ~i_scl & state.scl_prev;
    if (i_srst) begin
      // follow the synchronised levels, no false edge after reset
      next_state          = '0;
      next_state.sda_prev = i_sda;
      next_state.scl_prev = i_scl;
    end
  end

  always_ff @(posedge i_clk) begin
    state <= next_state;
  end

  assign o_start    = state.start;
  assign o_stop     = state.stop;
  assign o_scl_rise = state.scl_rise;
  assign o_scl_fall = state.scl_fall;

endmodule

// File: src/usu_core.sv
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "usu_cfg.svh"
// ==========================================================================
// universal serial shift unit with ahb-lite register slave
module usu_core (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_srst,
  // ahb-lite slave
  input  wire logic              i_hsel,
  input  wire usu_pkg::usu_word_t i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire usu_pkg::usu_word_t i_hwdata,
  input  wire logic              i_hready,
  output usu_pkg::usu_word_t     o_hrdata,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  // companion timer and cpu core
  input  wire logic              i_timer_match,
  input  wire logic              i_global_int_enable,
  // port direction and port bits
  input  wire logic              i_data_dir,
  input  wire logic              i_data_port_bit,
  input  wire logic              i_clock_dir,
  // serial pins
  input  wire logic              i_data_in_pin,
  input  wire logic              i_clock_pin,
  output logic                   o_do_out,
  output logic                   o_do_oe,
  output logic                   o_sda_out,
  output logic                   o_sda_oe,
  output logic                   o_scl_out,
  output logic                   o_scl_oe,
  // interrupts and wake
  output logic                   o_start_irq,
  output logic                   o_overflow_irq,
  output logic                   o_wake_any_sleep,
  output logic                   o_wake_idle
);
  import usu_pkg::*;

  // ========================================================================
  // state
  typedef struct packed {
    usu_bus_phase_t phase;
    logic           write;
    logic           word_size;
    logic [7:0]     addr_lo;
    logic           hreadyout;
    usu_word_t      hrdata;
    logic           sie;
    logic           oie;
    logic [1:0]     wm;
    logic [1:0]     cs;
    logic           clk_mode;
    logic           clock_port;
    usu_byte_t      shift;
    usu_byte_t      rxbuf;
    logic [3:0]     count;
    logic           start_f;
    logic           ovf_f;
    logic           stop_f;
    logic           latch;
    logic           start_irq;
    logic           ovf_irq;
    logic           wake_any;
    logic           wake_idle;
    logic           do_out;
    logic           do_oe;
    logic           sda_out;
    logic           sda_oe;
    logic           scl_out;
    logic           scl_oe;
  } usu_core_state_t;

  usu_core_state_t state;
  usu_core_state_t next_state;

  // ========================================================================
  // helpers
  function automatic logic [7:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx,
                                   input logic word);
    reg_hit = word & (addr == reg_addr(idx));
  endfunction

  function automatic logic ext_clock(input logic [1:0] cs);
    ext_clock = cs[1];
  endfunction

  // ========================================================================
  // pin synchronisers and detectors
  logic [1:0] pins_sync;
  logic       din_s;
  logic       clk_s;
  logic       det_start;
  logic       det_stop;
  logic       scl_rise;
  logic       scl_fall;

  usu_sync u_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_data_in_pin, i_clock_pin}),
    .o_sync  (pins_sync)
  );

  // inputs are used whatever the wire mode
  assign din_s = pins_sync[1];
  assign clk_s = pins_sync[0];

  usu_cond_detect u_detect (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_sda      (din_s),
    .i_scl      (clk_s),
    .i_two_wire (state.wm == `USU_WM_TWO),
    .o_start    (det_start),
    .o_stop     (det_stop),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall)
  );

  // ========================================================================
  // next state
  logic      acc;
  logic      wr_ctl;
  logic      wr_sts;
  logic      wr_dat;
  logic      rd;
  usu_byte_t wdata;
  logic      sw_clk;
  logic      sw_tog;
  logic      shift_tick;
  logic      count_tick;
  logic      ovf_evt;
  logic      start_evt;
  logic      transparent;
  usu_byte_t rdata;
  logic      collision;

  always_comb begin
    next_state  = state;
    acc         = (state.phase == USU_BUS_DATA);
    wdata       = i_hwdata[7:0];
    wr_ctl      = acc & state.write &
                  reg_hit(state.addr_lo, `USU_IDX_CONTROL, state.word_size);
    wr_sts      = acc & state.write &
                  reg_hit(state.addr_lo, `USU_IDX_STATUS, state.word_size);
    wr_dat      = acc & state.write &
                  reg_hit(state.addr_lo, `USU_IDX_DATA, state.word_size);
    rd          = acc & ~state.write;
    sw_clk      = wr_ctl & wdata[`USU_CTL_CLK];
    sw_tog      = wr_ctl & wdata[`USU_CTL_TOG];
    shift_tick  = 1'b0;
    count_tick  = 1'b0;
    ovf_evt     = 1'b0;
    start_evt   = 1'b0;
    transparent = 1'b1;
    rdata       = 8'h00;
    collision   = state.shift[7] ^ din_s;

    // ----------------------------------------------------------------------
    // bus phases: one wait state per transfer
    unique case (state.phase)
      USU_BUS_IDLE: begin
        if (i_hsel & i_htrans[1] & i_hready) begin
          next_state.phase     = USU_BUS_DATA;
          next_state.write     = i_hwrite;
          next_state.word_size = (i_hsize == `USU_HSIZE_WORD);
          next_state.addr_lo   = i_haddr[7:0];
          next_state.hreadyout = 1'b0;
        end
      end
      USU_BUS_DATA: begin
        next_state.phase     = USU_BUS_IDLE;
        next_state.hreadyout = 1'b1;
      end
    endcase

    // ----------------------------------------------------------------------
    // control register
    if (wr_ctl) begin
      next_state.sie      = wdata[`USU_CTL_SIE];
      next_state.oie      = wdata[`USU_CTL_OIE];
      next_state.wm       = wdata[`USU_CTL_WM_HI:`USU_CTL_WM_LO];
      next_state.cs       = wdata[`USU_CTL_CS_HI:`USU_CTL_CS_LO];
      next_state.clk_mode = wdata[`USU_CTL_CLK];
    end
    if (sw_tog) begin
      next_state.clock_port = ~state.clock_port;
    end

    // ----------------------------------------------------------------------
    // clock source selection
    unique case (next_state.cs)
      `USU_CS_SOFT:    shift_tick = sw_clk;
      `USU_CS_TIMER:   shift_tick = i_timer_match;
      `USU_CS_EXT_POS: shift_tick = scl_rise;
      `USU_CS_EXT_NEG: shift_tick = scl_fall;
    endcase
    if (ext_clock(next_state.cs)) begin
      if (next_state.clk_mode) begin
        count_tick = sw_tog;
      end else begin
        count_tick = scl_rise | scl_fall;
      end
    end else begin
      count_tick = shift_tick;
    end

    // ----------------------------------------------------------------------
    // shift register
    if (wr_dat) begin
      next_state.shift = wdata;
    end else if (shift_tick) begin
      next_state.shift = {state.shift[6:0], din_s};
    end

    // ----------------------------------------------------------------------
    // counter, overflow and receive buffer
    if (wr_sts) begin
      next_state.count = wdata[`USU_STS_CNT_HI:0];
    end else if (count_tick) begin
      next_state.count = state.count + 4'h1;
      ovf_evt          = (state.count == `USU_CNT_MAX);
    end
    if (ovf_evt) begin
      next_state.rxbuf = next_state.shift;
    end

    // ----------------------------------------------------------------------
    // status flags, set wins over clear
    if ((state.wm == `USU_WM_TWO) & det_start) begin
      start_evt = 1'b1;
    end
    if ((state.wm == `USU_WM_OFF) | (state.wm == `USU_WM_THREE)) begin
      if (ext_clock(state.cs) & ~state.clk_mode & (scl_rise | scl_fall)) begin
        start_evt = 1'b1;
      end
    end
    next_state.start_f = (state.start_f & ~(wr_sts & wdata[`USU_STS_START])) |
                         start_evt;
    next_state.ovf_f   = (state.ovf_f & ~(wr_sts & wdata[`USU_STS_OVF])) |
                         ovf_evt;
    next_state.stop_f  = (state.stop_f & ~(wr_sts & wdata[`USU_STS_STOP])) |
                         det_stop;

    // ----------------------------------------------------------------------
    // output latch
    if (next_state.cs == `USU_CS_EXT_POS) begin
      transparent = ~clk_s;
    end else if (next_state.cs == `USU_CS_EXT_NEG) begin
      transparent = clk_s;
    end
    if (transparent) begin
      next_state.latch = next_state.shift[7];
    end

    // ----------------------------------------------------------------------
    // pin drivers
    next_state.do_out  = next_state.latch;
    next_state.do_oe   = 1'b0;
    next_state.sda_out = 1'b0;
    next_state.sda_oe  = 1'b0;
    next_state.scl_out = 1'b0;
    next_state.scl_oe  = 1'b0;
    if (next_state.wm == `USU_WM_THREE) begin
      next_state.do_oe   = i_data_dir;
      next_state.scl_out = next_state.clock_port;
      next_state.scl_oe  = i_clock_dir;
    end else if (next_state.wm == `USU_WM_TWO) begin
      next_state.sda_oe = i_data_dir & (~next_state.latch | ~i_data_port_bit);
      next_state.scl_oe = i_clock_dir & (~next_state.clock_port |
                          next_state.start_f | next_state.ovf_f);
    end

    // ----------------------------------------------------------------------
    // interrupt and wake requests
    next_state.start_irq = next_state.start_f & next_state.sie & i_global_int_enable;
    next_state.ovf_irq   = next_state.ovf_f & next_state.oie & i_global_int_enable;
    next_state.wake_any  = next_state.start_f & next_state.sie;
    next_state.wake_idle = next_state.ovf_f & next_state.oie;

    // ----------------------------------------------------------------------
    // read data, reads have no side effects
    if (reg_hit(state.addr_lo, `USU_IDX_CONTROL, state.word_size)) begin
      rdata = {state.sie, state.oie, state.wm, state.cs, 2'b00};
    end else if (reg_hit(state.addr_lo, `USU_IDX_STATUS, state.word_size)) begin
      rdata = {state.start_f, state.ovf_f, state.stop_f,
               collision, state.count};
    end else if (reg_hit(state.addr_lo, `USU_IDX_DATA, state.word_size)) begin
      rdata = state.shift;
    end else if (reg_hit(state.addr_lo, `USU_IDX_BUFFER, state.word_size)) begin
      rdata = state.rxbuf;
    end
    if (rd) begin
      next_state.hrdata = {24'h000000, rdata};
    end

    // ----------------------------------------------------------------------
    // synchronous reset
    if (i_srst) begin
      next_state            = '0;
      next_state.phase      = USU_BUS_IDLE;
      next_state.hreadyout  = 1'b1;
      next_state.sie        = 1'(`USU_RST_CONTROL >> `USU_CTL_SIE);
      next_state.oie        = 1'(`USU_RST_CONTROL >> `USU_CTL_OIE);
      next_state.wm         = 2'(`USU_RST_CONTROL >> `USU_CTL_WM_LO);
      next_state.cs         = 2'(`USU_RST_CONTROL >> `USU_CTL_CS_LO);
      next_state.clk_mode   = 1'(`USU_RST_CONTROL >> `USU_CTL_CLK);
      next_state.start_f    = 1'(`USU_RST_STATUS >> `USU_STS_START);
      next_state.ovf_f      = 1'(`USU_RST_STATUS >> `USU_STS_OVF);
      next_state.stop_f     = 1'(`USU_RST_STATUS >> `USU_STS_STOP);
      next_state.shift      = `USU_RST_DATA;
      next_state.rxbuf      = `USU_RST_BUFFER;
      next_state.count      = 4'(`USU_RST_STATUS & 8'h0F);
    end
  end

  always_ff @(posedge i_clk) begin
    state <= next_state;
  end

  // ========================================================================
  // outputs
  assign o_hrdata         = state.hrdata;
  assign o_hreadyout      = state.hreadyout;
  assign o_hresp          = 1'b0;
  assign o_do_out         = state.do_out;
  assign o_do_oe          = state.do_oe;
  assign o_sda_out        = state.sda_out;
  assign o_sda_oe         = state.sda_oe;
  assign o_scl_out        = state.scl_out;
  assign o_scl_oe         = state.scl_oe;
  assign o_start_irq      = state.start_irq;
  assign o_overflow_irq   = state.ovf_irq;
  assign o_wake_any_sleep = state.wake_any;
  assign o_wake_idle      = state.wake_idle;

endmodule

// File: dv/usu_far_end.sv
`timescale 1ns/100ps
// ==========================================================================
// far-end serial master, clock still between frames, lines pulled up
module usu_far_end (
  // line levels, high means released
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl <= 1'b0;
    o_sda <= 1'b1;
  end
  // one clock period of 160 ns carrying one bit
  task automatic pulse(input logic b);
    o_sda <= b;
    #40 o_scl <= 1'b1;
    #80 o_scl <= 1'b0;
    #40 o_sda <= 1'b1;
  endtask
  // data falls while clock high
  task automatic start_cond();
    o_scl <= 1'b1;
    #80 o_sda <= 1'b0;
    #80 o_scl <= 1'b0;
    #80 o_sda <= 1'b1;
  endtask
  // data rises while clock high
  task automatic stop_cond();
    o_sda <= 1'b0;
    #80 o_scl <= 1'b1;
    #80 o_sda <= 1'b1;
    #80 o_scl <= 1'b0;
  endtask
endmodule

// File: dv/usu_core_assertions.sv
`timescale 1ns/100ps
// ==========================================================================
// port checks of the shift unit
module usu_core_assertions (
  input wire logic               i_clk,
  input wire logic               i_srst,
  input wire logic               i_hsel,
  input wire logic [1:0]         i_htrans,
  input wire logic               i_hready,
  input wire logic               i_global_int_enable,
  input wire logic               i_data_dir,
  input wire usu_pkg::usu_word_t o_hrdata,
  input wire logic               o_hreadyout,
  input wire logic               o_hresp,
  input wire logic               o_do_oe,
  input wire logic               o_sda_oe,
  input wire logic               o_start_irq,
  input wire logic               o_overflow_irq,
  input wire logic               o_wake_any_sleep,
  input wire logic               o_wake_idle
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  a_resp_always_okay: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  a_one_wait_state: assert property (i_hsel && i_htrans[1] && i_hready
    |=> !o_hreadyout ##1 o_hreadyout) else $error("wait state count wrong");
  a_upper_bytes_zero: assert property (o_hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_quiet_after_reset: assert property ($past(i_srst) |-> o_hreadyout && !o_do_oe
    && !o_sda_oe && !o_start_irq && !o_overflow_irq) else $error("not quiet after reset");
  a_drive_needs_dir: assert property ((o_do_oe || o_sda_oe) |-> $past(i_data_dir))
    else $error("pin driven without direction");
  a_irq_needs_global: assert property ((o_start_irq || o_overflow_irq)
    |-> $past(i_global_int_enable)) else $error("interrupt without global enable");
  a_start_wakes_all: assert property (o_start_irq |-> o_wake_any_sleep)
    else $error("start interrupt without wake");
  a_ovf_wakes_idle: assert property (o_overflow_irq |-> o_wake_idle)
    else $error("overflow interrupt without idle wake");
  c_transfer: cover property (i_hsel && i_htrans[1] && i_hready);
  c_ovf_irq: cover property ($rose(o_overflow_irq));
  c_start_irq: cover property ($rose(o_start_irq));
endmodule

bind usu_core usu_core_assertions chk (.i_clk, .i_srst, .i_hsel, .i_htrans, .i_hready,
  .i_global_int_enable, .i_data_dir, .o_hrdata, .o_hreadyout, .o_hresp, .o_do_oe,
  .o_sda_oe, .o_start_irq, .o_overflow_irq, .o_wake_any_sleep, .o_wake_idle);

// File: dv/tb_universal_serial_shift_unit_regs.sv
`timescale 1ns/100ps
`include "usu_cfg.svh"
// ==========================================================================
// self-checking bench of the shift unit
module tb_universal_serial_shift_unit_regs;
  import usu_pkg::*;
  localparam logic [5:0] CT = `USU_IDX_CONTROL;
  localparam logic [5:0] ST = `USU_IDX_STATUS;
  localparam logic [5:0] DT = `USU_IDX_DATA;
  localparam logic [5:0] BF = `USU_IDX_BUFFER;
  logic      i_clk, i_srst, hsel, hwrite, tmatch, gie, ddir, cdir;
  logic      [1:0] htrans;
  usu_word_t haddr, hwdata, o_hrdata;
  logic      o_hreadyout, o_do_out, o_do_oe, o_sda_out, o_sda_oe, o_scl_out, o_scl_oe;
  logic      o_start_irq, o_overflow_irq, o_wake_any_sleep, o_wake_idle;
  wire logic far_scl, far_sda, scl_line, sda_line;
  int        bad_count, check_count, cyc;
  usu_byte_t q;
  // ========================================================================
  // wired lines from all drivers
  assign scl_line = o_scl_oe ? (o_scl_out & far_scl) : far_scl;
  assign sda_line = far_sda & ~o_sda_oe;
  usu_far_end far (.o_scl(far_scl), .o_sda(far_sda));
  usu_core dut (.i_clk, .i_srst, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(`USU_HSIZE_WORD), .i_hwdata(hwdata), .i_hready(o_hreadyout),
    .o_hrdata, .o_hreadyout, .o_hresp(), .i_timer_match(tmatch), .i_global_int_enable(gie),
    .i_data_dir(ddir), .i_data_port_bit(1'b1), .i_clock_dir(cdir), .i_data_in_pin(sda_line),
    .i_clock_pin(scl_line), .o_do_out, .o_do_oe, .o_sda_out, .o_sda_oe, .o_scl_out, .o_scl_oe,
    .o_start_irq, .o_overflow_irq, .o_wake_any_sleep, .o_wake_idle);
  // ========================================================================
  // clock and timeout
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ========================================================================
  // shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input usu_byte_t seen, input usu_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic bus(input logic wr, input logic [5:0] idx, input usu_byte_t d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, idx, 2'h0};
    hwrite <= wr;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    q = o_hrdata[7:0];
  endtask
  task automatic rc(input logic [5:0] idx, input usu_byte_t m, input usu_byte_t exp);
    bus(1'b0, idx, 8'h00);
    chk(q & m, exp);
  endtask
  // ========================================================================
  // scenarios
  task automatic t_reset();
    rc(CT, 8'hFF, 8'h00);
    rc(ST, 8'hEF, 8'h00);
    bus(1'b1, 6'h20, 8'hFF);
    rc(6'h20, 8'hFF, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_soft_shift();
    bus(1'b1, CT, 8'h40);
    bus(1'b1, DT, 8'hA5);
    bus(1'b1, ST, 8'hEE);
    bus(1'b1, CT, 8'h42);
    bus(1'b1, CT, 8'h42);
    rc(DT, 8'hFF, 8'h97);
    rc(ST, 8'hFF, 8'h40);
    rc(BF, 8'hFF, 8'h97);
    rc(ST, 8'hFF, 8'h40);
    chk(o_overflow_irq, 8'h01);
    chk(o_wake_idle, 8'h01);
    gie <= 1'b0;
    w(3);
    chk(o_overflow_irq, 8'h00);
    gie <= 1'b1;
    bus(1'b1, ST, 8'h40);
    rc(ST, 8'hFF, 8'h00);
    $display("software shift test done");
  endtask
  task automatic t_timer();
    bus(1'b1, CT, 8'h04);
    bus(1'b1, ST, 8'hE0);
    tmatch <= 1'b1;
    w(1);
    tmatch <= 1'b0;
    rc(ST, 8'h0F, 8'h01);
    tmatch <= 1'b1;
    bus(1'b1, DT, 8'h3C);
    tmatch <= 1'b0;
    rc(DT, 8'hFF, 8'h79);
    $display("timer test done");
  endtask
  task automatic t_ext_edge();
    bus(1'b1, CT, 8'h08);
    bus(1'b1, DT, 8'h00);
    bus(1'b1, ST, 8'hE0);
    far.pulse(1'b1);
    w(6);
    rc(DT, 8'hFF, 8'h01);
    rc(ST, 8'hFF, 8'h92);
    bus(1'b1, CT, 8'h88);
    w(2);
    chk(o_start_irq, 8'h01);
    chk(o_wake_any_sleep, 8'h01);
    bus(1'b1, ST, 8'h80);
    rc(ST, 8'h80, 8'h00);
    $display("external clock test done");
  endtask
  task automatic t_toggle();
    bus(1'b1, CT, 8'h0A);
    bus(1'b1, ST, 8'hE0);
    repeat (3) bus(1'b1, CT, 8'h0B);
    rc(ST, 8'h0F, 8'h03);
    $display("toggle test done");
  endtask
  task automatic t_dout();
    bus(1'b1, CT, 8'h10);
    ddir <= 1'b1;
    bus(1'b1, DT, 8'h80);
    w(3);
    chk({o_do_oe, o_do_out}, 8'h03);
    chk(o_scl_out, 8'h01);
    bus(1'b1, DT, 8'h00);
    w(3);
    chk(o_do_out, 8'h00);
    ddir <= 1'b0;
    w(3);
    chk(o_do_oe, 8'h00);
    $display("data out test done");
  endtask
  task automatic t_two_wire();
    cdir <= 1'b1;
    bus(1'b1, CT, 8'h20);
    bus(1'b1, DT, 8'hFF);
    bus(1'b1, ST, 8'hE0);
    far.start_cond();
    w(6);
    rc(ST, 8'hE0, 8'h80);
    chk(o_scl_oe, 8'h01);
    bus(1'b1, ST, 8'h80);
    w(3);
    chk(o_scl_oe, 8'h00);
    bus(1'b1, CT, 8'hE0);
    far.stop_cond();
    w(6);
    rc(ST, 8'hE0, 8'h20);
    chk(o_start_irq, 8'h00);
    bus(1'b1, DT, 8'h00);
    rc(ST, 8'h10, 8'h10);
    chk(o_sda_out, 8'h00);
    ddir <= 1'b1;
    w(3);
    chk(o_sda_oe, 8'h01);
    rc(ST, 8'h10, 8'h00);
    $display("two-wire test done");
  endtask
  // ========================================================================
  // main sequence
  initial begin
    {hsel, hwrite, tmatch, ddir, cdir} = 5'h00;
    gie = 1'b1;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    {bad_count, check_count, cyc} = 0;
    i_srst = 1'b1;
    w(5);
    i_srst <= 1'b0;
    w(1);
    t_reset();
    t_soft_shift();
    t_timer();
    t_ext_edge();
    t_toggle();
    t_dout();
    t_two_wire();
    report_and_stop();
  end
endmodule
